//--- core/ics_map.svh
// Register offsets, field positions and reset values of the capture selection block
`ifndef ICS_MAP_SVH
`define ICS_MAP_SVH

// ============================================================
// Register byte offsets
`define ICS_CONFIG_OFS     12'h000
`define ICS_STATUS_OFS     12'h004
`define ICS_INT_STAT_OFS   12'h008
`define ICS_INT_MASK_OFS   12'h00C

// ============================================================
// Field widths and positions
`define ICS_CFG_W          7
`define ICS_STRAP_W        8
`define ICS_EVT_W          2
`define ICS_EVT_HOTPLUG    0
`define ICS_EVT_MODE       1

// ============================================================
// Reset values
`define ICS_CFG_RESET      7'h00
`define ICS_DEFAULT_TRIM   3'h3

`endif

//--- core/ics_pkg.sv
// Types shared by the capture selection block
package ics_pkg;

  // Configuration word, as held in the config register
  typedef struct packed {
    logic       bus_24bit;
    logic       rising_edge;
    logic [2:0] trim;
    logic       deskew_en;
    logic       power_up;
  } cfg_t;

  // Strap pins after synchronisation
  typedef struct packed {
    logic       serial_sel;
    logic       bus_width;
    logic       power_n;
    logic [2:0] trim;
    logic       deskew;
    logic       edge_hp;
  } strap_t;

endpackage

//--- core/input_capture_config_select.sv
// Capture edge, de-skew and power-down selection from straps or APB registers
`timescale 1ns/1ns
`default_nettype none
`include "ics_map.svh"

module input_capture_config_select
  import ics_pkg::*;
#(
  parameter logic [2:0] DEFAULT_TRIM = `ICS_DEFAULT_TRIM
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Strap pins
  input  wire logic        edge_select_hotplug_pin_i,
  input  wire logic        deskew_enable_i,
  input  wire logic [2:0]  deskew_trim_select_i,
  input  wire logic        power_down_n_i,
  input  wire logic        serial_config_select_i,
  input  wire logic        bus_width_select_i,
  // Selected configuration
  output logic             capture_rising_o,
  output logic             deskew_en_o,
  output logic [2:0]       deskew_trim_o,
  output logic             bus_24bit_o,
  output logic             power_down_o,
  output logic             core_enable_o,
  output logic             hotplug_o,
  output logic             serial_mode_o,
  output logic             irq_o
);

  // ============================================================
  // Synchroniser
  strap_t strap_raw;
  strap_t strap_meta_q;
  strap_t strap_q;

  assign strap_raw = '{serial_sel: serial_config_select_i,
                       bus_width:  bus_width_select_i,
                       power_n:    power_down_n_i,
                       trim:       deskew_trim_select_i,
                       deskew:     deskew_enable_i,
                       edge_hp:    edge_select_hotplug_pin_i};

  // Two flops per strap bit, first flop read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < `ICS_STRAP_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          strap_meta_q[gi] <= 1'b0;
          strap_q[gi]      <= 1'b0;
        end else begin
          strap_meta_q[gi] <= strap_raw[gi];
          strap_q[gi]      <= strap_meta_q[gi];
        end
      end
    end
  endgenerate

  // ============================================================
  // APB decode
  logic serial_en;
  logic apb_access;
  logic apb_done;
  logic apb_wr;
  logic hit_cfg;
  logic hit_stat;
  logic hit_ist;
  logic hit_imsk;
  logic hit_any;

  assign serial_en  = strap_q.serial_sel;
  assign apb_access = psel_i && penable_i;
  assign apb_done   = apb_access && pready_o;
  assign apb_wr     = apb_done && pwrite_i;
  assign hit_cfg    = paddr_i == `ICS_CONFIG_OFS;
  assign hit_stat   = paddr_i == `ICS_STATUS_OFS;
  assign hit_ist    = paddr_i == `ICS_INT_STAT_OFS;
  assign hit_imsk   = paddr_i == `ICS_INT_MASK_OFS;
  assign hit_any    = hit_cfg || hit_stat || hit_ist || hit_imsk;

  // ============================================================
  // Configuration register
  cfg_t cfg_q;
  cfg_t cfg_d;

  // Held at defaults while serial mode is off; writes ignored then
  assign cfg_d = !serial_en ? cfg_t'(`ICS_CFG_RESET) :
                 (apb_wr && hit_cfg) ? cfg_t'(pwdata_i[`ICS_CFG_W-1:0]) :
                 cfg_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= cfg_t'(`ICS_CFG_RESET);
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ============================================================
  // Events and interrupt
  logic                  hp_prev_q;
  logic                  mode_prev_q;
  logic [`ICS_EVT_W-1:0] evt;
  logic [`ICS_EVT_W-1:0] int_stat_q;
  logic [`ICS_EVT_W-1:0] int_stat_d;
  logic [`ICS_EVT_W-1:0] int_mask_q;
  logic [`ICS_EVT_W-1:0] int_mask_d;
  logic [`ICS_EVT_W-1:0] w1c;

  // Hot-plug change counts only in serial mode
  assign evt[`ICS_EVT_HOTPLUG] = serial_en && (strap_q.edge_hp != hp_prev_q);
  assign evt[`ICS_EVT_MODE]    = serial_en != mode_prev_q;
  assign w1c        = (apb_wr && hit_ist) ? pwdata_i[`ICS_EVT_W-1:0] : '0;
  assign int_stat_d = (int_stat_q & ~w1c) | evt;  // Set wins over clear
  assign int_mask_d = (apb_wr && hit_imsk) ? pwdata_i[`ICS_EVT_W-1:0] : int_mask_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hp_prev_q   <= 1'b0;
      mode_prev_q <= 1'b0;
      int_stat_q  <= '0;
      int_mask_q  <= '0;
    end else begin
      hp_prev_q   <= strap_q.edge_hp;
      mode_prev_q <= serial_en;
      int_stat_q  <= int_stat_d;
      int_mask_q  <= int_mask_d;
    end
  end

  // ============================================================
  // Source selection
  logic       sel_rising;
  logic       sel_dk_en;
  logic [2:0] sel_trim;
  logic       sel_bus24;
  logic       sel_pd;

  assign sel_rising = serial_en ? cfg_q.rising_edge : strap_q.edge_hp;
  assign sel_dk_en  = serial_en ? cfg_q.deskew_en : strap_q.deskew;
  // Trim step applies only while de-skew is on
  assign sel_trim   = !sel_dk_en ? DEFAULT_TRIM :
                      serial_en ? cfg_q.trim : strap_q.trim;
  assign sel_bus24  = serial_en ? cfg_q.bus_24bit : strap_q.bus_width;
  assign sel_pd     = serial_en ? !cfg_q.power_up : !strap_q.power_n;

  // ============================================================
  // Registered outputs
  logic [31:0] rdata;

  assign rdata = hit_cfg  ? {25'h000_0000, cfg_q} :
                 hit_stat ? {29'h000_0000, sel_pd, serial_en, strap_q.edge_hp} :
                 hit_ist  ? {30'h0000_0000, int_stat_q} :
                 hit_imsk ? {30'h0000_0000, int_mask_q} : 32'h0000_0000;

  // One wait state; bus stays alive in power-down
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= apb_access && !pready_o;
      prdata_o  <= (apb_access && !pready_o && !pwrite_i) ? rdata : 32'h0000_0000;
      pslverr_o <= apb_access && !pready_o && !hit_any;
    end
  end

  // Selected configuration to the capture logic
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      capture_rising_o <= 1'b0;
      deskew_en_o      <= 1'b0;
      deskew_trim_o    <= DEFAULT_TRIM;
      bus_24bit_o      <= 1'b0;
      power_down_o     <= 1'b1;
      core_enable_o    <= 1'b0;
      hotplug_o        <= 1'b0;
      serial_mode_o    <= 1'b0;
      irq_o            <= 1'b0;
    end else begin
      capture_rising_o <= sel_rising;
      deskew_en_o      <= sel_dk_en;
      deskew_trim_o    <= sel_trim;
      bus_24bit_o      <= sel_bus24;
      power_down_o     <= sel_pd;
      core_enable_o    <= !sel_pd;
      hotplug_o        <= serial_en && strap_q.edge_hp;
      serial_mode_o    <= serial_en;
      irq_o            <= |(int_stat_d & int_mask_d);
    end
  end

  // ============================================================
  // Assertions
  property p_strap_edge;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !serial_en |=> capture_rising_o == $past(strap_q.edge_hp);
  endproperty
  a_strap_edge: assert property (p_strap_edge) else $error("edge strap not applied");

  property p_reg_edge;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    serial_en |=> capture_rising_o == $past(cfg_q.rising_edge)
                  && hotplug_o == $past(strap_q.edge_hp);
  endproperty
  a_reg_edge: assert property (p_reg_edge) else $error("hot-plug mode wrong");

  property p_trim_on;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !serial_en && strap_q.deskew |=> deskew_en_o && deskew_trim_o == $past(strap_q.trim);
  endproperty
  a_trim_on: assert property (p_trim_on) else $error("strap trim not applied");

  property p_trim_off;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !deskew_en_o |-> deskew_trim_o == DEFAULT_TRIM;
  endproperty
  a_trim_off: assert property (p_trim_off) else $error("default trim missing");

  property p_reg_deskew;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    serial_en && cfg_q.deskew_en |=> deskew_en_o && deskew_trim_o == $past(cfg_q.trim);
  endproperty
  a_reg_deskew: assert property (p_reg_deskew) else $error("register de-skew ignored");

  property p_strap_pd;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !serial_en |=> power_down_o == !$past(strap_q.power_n) && core_enable_o == !power_down_o;
  endproperty
  a_strap_pd: assert property (p_strap_pd) else $error("power pin not applied");

  property p_reg_pd;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    serial_en |=> power_down_o == !$past(cfg_q.power_up);
  endproperty
  a_reg_pd: assert property (p_reg_pd) else $error("power bit not applied");

  property p_cfg_default;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !serial_en ##1 serial_en |-> cfg_q == cfg_t'(`ICS_CFG_RESET) ##1 power_down_o;
  endproperty
  a_cfg_default: assert property (p_cfg_default) else $error("config not default");

  property p_bus_width;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !serial_en |=> bus_24bit_o == $past(strap_q.bus_width);
  endproperty
  a_bus_width: assert property (p_bus_width) else $error("bus width strap wrong");

  property p_sync;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ##2 1'b1 |-> strap_q.serial_sel == $past(serial_config_select_i, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("strap sync depth wrong");

  property p_apb_alive;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    apb_access && !pready_o |=> pready_o;
  endproperty
  a_apb_alive: assert property (p_apb_alive) else $error("APB stalled");

  // Interrupt line follows the latched status under the mask
  property p_irq_level;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    irq_o == |(int_stat_q & int_mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  c_serial_enter: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !serial_en ##1 serial_en);
  c_hotplug_irq: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    evt[`ICS_EVT_HOTPLUG] ##1 irq_o);
  c_power_up: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    serial_en && power_down_o ##1 !power_down_o);
  c_irq_clear: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    irq_o ##1 !irq_o);

endmodule
`default_nettype wire

//--- verification/board_pins_model.sv
// Board straps and hot-plug level driving the strap pins, all as requested by the bench
`timescale 1ns/1ns
`default_nettype none

module board_pins_model
  import ics_pkg::*;
(
  // Levels requested by the bench
  input  wire strap_t     want_i,
  // Pins toward the block
  output logic            edge_hp_o,
  output logic            deskew_o,
  output logic [2:0]      trim_o,
  output logic            power_n_o,
  output logic            serial_sel_o,
  output logic            bus_width_o
);
  // ==========================================
  // Static levels; hot-plug follows the bench request like the other pins
  assign edge_hp_o    = want_i.edge_hp;
  assign deskew_o     = want_i.deskew;
  assign trim_o       = want_i.trim;
  assign power_n_o    = want_i.power_n;
  assign serial_sel_o = want_i.serial_sel;
  assign bus_width_o  = want_i.bus_width;
endmodule

`default_nettype wire

//--- verification/input_capture_config_select_test.sv
// Self-checking bench of the capture selection block
`timescale 1ns/1ns
`default_nettype none
`include "ics_map.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end

module input_capture_config_select_test
  import ics_pkg::*;
;
  localparam logic [2:0] DTRIM = 3'h3;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic        pready, pslverr, rerr, e_p, d_p, p_p, s_p, b_p;
  logic        cap_r, dk_en, b24, pdown, core_en, hp, smode, irq;
  logic [2:0]  trim_p, trim_o;
  strap_t      want = '0;
  int          num_errors = 0, checked = 0;

  // ==========================================
  // Clock, design and board
  always #2 sys_clk = ~sys_clk;
  board_pins_model brd_u (.want_i(want), .edge_hp_o(e_p), .deskew_o(d_p), .trim_o(trim_p),
    .power_n_o(p_p), .serial_sel_o(s_p), .bus_width_o(b_p));
  input_capture_config_select #(.DEFAULT_TRIM(DTRIM)) dut_u (.sys_clk_i(sys_clk),
    .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .edge_select_hotplug_pin_i(e_p), .deskew_enable_i(d_p),
    .deskew_trim_select_i(trim_p), .power_down_n_i(p_p), .serial_config_select_i(s_p),
    .bus_width_select_i(b_p), .capture_rising_o(cap_r), .deskew_en_o(dk_en),
    .deskew_trim_o(trim_o), .bus_24bit_o(b24), .power_down_o(pdown),
    .core_enable_o(core_en), .hotplug_o(hp), .serial_mode_o(smode), .irq_o(irq));

  // ==========================================
  // APB master transfer, waits for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin num_errors++; $display("Error %0t: no pready", $time); end
  endtask

  task automatic settle();
    repeat (5) @(posedge sys_clk);
  endtask

  // Strap mode: every pin level maps to its output
  task automatic t_straps();
    for (int i = 0; i < 2; i++) begin
      want <= '{1'b0, i[0], i[0], 3'h6, i[0], i[0]};
      settle();
      `CHK(cap_r, i[0])
      `CHK(dk_en, i[0])
      `CHK(trim_o, i ? 3'h6 : DTRIM)
      `CHK(b24, i[0])
      `CHK({pdown, core_en}, {~i[0], i[0]})
      `CHK({hp, smode}, 2'b00)
    end
    apb(1'b1, `ICS_CONFIG_OFS, 32'h0000_0077);
    apb(1'b0, `ICS_CONFIG_OFS, 32'h0000_0000);
    `CHK(rdat, 32'h0000_0000)
  endtask

  // Serial mode: powered down, registers rule, straps ignored
  task automatic t_serial();
    want <= '{1'b1, 1'b1, 1'b1, 3'h6, 1'b1, 1'b1};
    settle();
    `CHK({smode, pdown, core_en, hp}, 4'b1101)
    `CHK({dk_en, trim_o}, {1'b0, DTRIM})
    apb(1'b1, `ICS_CONFIG_OFS, 32'h0000_0077);
    settle();
    `CHK({dk_en, trim_o, cap_r, b24}, 6'b110111)
    `CHK({pdown, core_en}, 2'b01)
    apb(1'b0, `ICS_STATUS_OFS, 32'h0000_0000);
    `CHK(rdat, 32'h0000_0003)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK(rerr, 1'b1)
  endtask

  // Hot-plug event, mask and clear, then select toggle
  task automatic t_irq_reset();
    apb(1'b1, `ICS_INT_STAT_OFS, 32'h0000_0003);
    want.edge_hp <= 1'b0;
    settle();
    `CHK({hp, irq}, 2'b00)
    apb(1'b1, `ICS_INT_MASK_OFS, 32'h0000_0001);
    settle();
    `CHK(irq, 1'b1)
    apb(1'b1, `ICS_INT_STAT_OFS, 32'h0000_0001);
    settle();
    `CHK(irq, 1'b0)
    want.serial_sel <= 1'b0;
    settle();
    want.serial_sel <= 1'b1;
    settle();
    apb(1'b0, `ICS_CONFIG_OFS, 32'h0000_0000);
    `CHK(rdat, 32'h0000_0000)
    `CHK({pdown, dk_en, trim_o}, {2'b10, DTRIM})
    apb(1'b0, `ICS_INT_STAT_OFS, 32'h0000_0000);
    `CHK(rdat, 32'h0000_0002)
    apb(1'b0, `ICS_INT_MASK_OFS, 32'h0000_0000);
    `CHK(rdat, 32'h0000_0001)
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_straps();
    t_serial();
    t_irq_reset();
    print_verdict();
  end

  initial begin
    #40000;
    num_errors++;
    print_verdict();
  end
endmodule

`default_nettype wire
